// ===== bench/test_pfc_debug_flag_bank.sv
`timescale 1ns/100ps
module test_pfc_debug_flag_bank
  import flag_bank_pkg::*;
;
  logic        clk_sys;
  logic        reset;
  cond_t       condIn;
  logic        rdEn;
  logic [15:0] rdAddr;
  logic [7:0]  rdData_q;
  logic        rdHit_q;
  int          error_cnt;
  int          samples_checked;
  int          testNum;
  logic [31:0] seed;

  pfc_debug_flag_bank u_dut (.clk_sys(clk_sys), .reset(reset), .condIn(condIn), .rdEn(rdEn),
    .rdAddr(rdAddr), .rdData_q(rdData_q), .rdHit_q(rdHit_q));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // returns {hit, data} for a read of address a with conditions c
  function automatic logic [8:0] expVal(cond_t c, logic [15:0] a);
    logic inSum;
    logic ovSum;
    inSum = c.lineUndervoltFault | c.lineUndervoltWarning | c.lineOvervoltFault
          | c.inputOverpowerWarning | c.inputOvercurrentWarning | c.inputOvercurrentFault
          | c.quickCurrentTrip;
    ovSum = c.outputOvervoltFault | c.quickOutputOvervoltTrip;
    case (a)
      ADDR_INPUT_SUPPLY: return {1'b1, c.lineBelowTurnoff | c.lineUndervoltFault,
        c.lineBelowTurnoff, c.lineUndervoltFault, c.lineUndervoltWarning, c.highLine,
        c.lineSagIndicator, c.commMemoryLogicFault, c.auxRailOvervolt};
      ADDR_INPUT_LIMIT: return {1'b1, c.lineOvervoltFault, c.coreRailOvervolt,
        c.inputOverpowerWarning, c.linePeriodUndetected, c.inputOvercurrentWarning,
        c.inputOvercurrentFault, c.quickCurrentTrip, inSum};
      ADDR_OUTPUT_VOLT: return {1'b1, c.dividerOpenDetect, c.quickOutputOvervoltTrip,
        c.outputUndervoltFault, c.outputUndervoltWarning, c.outputOvervoltWarning,
        c.outputOvervoltFault, ovSum, ovSum | c.outputOvervoltWarning
        | c.outputUndervoltFault | c.outputUndervoltWarning};
      ADDR_POWER_MODE: return {1'b1, RSVD_VALUE, c.lowPowerMode, c.auxRailUndervolt,
        c.inrushRelayOff};
      default: return 9'h000;
    endcase
  endfunction

  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // request held from just after one edge until the edge that takes it
  task automatic rd(logic [15:0] a);
    logic [8:0] e;
    e = expVal(condIn, a);
    rdEn = 1'b1;
    rdAddr = a;
    @(posedge clk_sys);
    #1;
    chk("hit", {7'h00, e[8]}, {7'h00, rdHit_q});
    chk("data", e[7:0], rdData_q);
  endtask

  task automatic run(cond_t c);
    logic [31:0] r;
    r = xs();
    condIn = c;
    // two-stage synchroniser plus flag register
    repeat (3) @(posedge clk_sys);
    #1;
    rd(ADDR_INPUT_SUPPLY);
    rd(ADDR_INPUT_LIMIT);
    rd(ADDR_OUTPUT_VOLT);
    rd(ADDR_POWER_MODE);
    rd(16'hFE97);
    rd(16'hFE9C);
    rd(r[15:0]);
    rdEn = 1'b0;
    @(posedge clk_sys);
    #1;
    chk("idle hit", 8'h00, {7'h00, rdHit_q});
    chk("idle data", 8'h00, rdData_q);
    testNum++;
    $display("test %0d done", testNum);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    logic [31:0] r;
    seed = 32'h000058EA;
    error_cnt = 0;
    samples_checked = 0;
    testNum = 0;
    reset = 1'b1;
    rdEn = 1'b0;
    rdAddr = 16'h0000;
    condIn = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("reset hit", 8'h00, {7'h00, rdHit_q});
    run('0);
    run('1);
    for (int i = 0; i < COND_W; i++)
      run(cond_t'(23'h000001 << i));
    for (int i = 0; i < 20; i++)
    begin
      r = xs();
      run(cond_t'(r[22:0]));
    end
    report_and_stop();
  end
endmodule // test_pfc_debug_flag_bank

// ===== core/flag_bank_pkg.sv
package flag_bank_pkg;

  // register addresses on the management bus (16-bit command space)
  localparam logic [15:0] ADDR_INPUT_SUPPLY = 16'hFE98;
  localparam logic [15:0] ADDR_INPUT_LIMIT  = 16'hFE99;
  localparam logic [15:0] ADDR_OUTPUT_VOLT  = 16'hFE9A;
  localparam logic [15:0] ADDR_POWER_MODE   = 16'hFE9B;
  localparam logic [7:0]  FLAGS_RESET       = 8'h00;
  localparam logic [4:0]  RSVD_VALUE        = 5'h00;

  // raw conditions from the supervisory comparators, sampled through synchronisers
  typedef struct packed {
    logic lineBelowTurnoff;         // line below turn-off threshold
    logic lineUndervoltFault;
    logic lineUndervoltWarning;
    logic highLine;
    logic lineSagIndicator;         // line below turn-on threshold
    logic commMemoryLogicFault;
    logic auxRailOvervolt;
    logic lineOvervoltFault;
    logic coreRailOvervolt;
    logic inputOverpowerWarning;
    logic linePeriodUndetected;
    logic inputOvercurrentWarning;
    logic inputOvercurrentFault;
    logic quickCurrentTrip;
    logic dividerOpenDetect;
    logic quickOutputOvervoltTrip;
    logic outputUndervoltFault;
    logic outputUndervoltWarning;
    logic outputOvervoltWarning;
    logic outputOvervoltFault;
    logic lowPowerMode;
    logic auxRailUndervolt;
    logic inrushRelayOff;
  } cond_t;

  localparam int COND_W = $bits(cond_t);

  // read-side view of the four registers
  typedef struct packed {
    logic [7:0] inputSupply;
    logic [7:0] inputLimit;
    logic [7:0] outputVolt;
    logic [7:0] powerMode;
  } flags_t;

endpackage

// ===== core/pfc_debug_flag_bank.sv
// Behaviour
// - bit7 reg0: general line undervoltage summary
// - bit6: line below turn-off threshold
// - bits5,4: undervolt fault, warning thresholds
// - bit3: line above high-line threshold
// - bit2: line sag below turn-on
// - bit1: communication, memory or logic fault
// - bit0: auxiliary rail overvoltage
// - reg1 bit7: line overvoltage fault
// - reg1 bit6: core rail overvoltage
// - bit0 input summary, bit5 overpower warning
// - bit4: line period undetected
// - bits3,2: overcurrent warning, fault
// - bit1: current limit pin trip
// - reg2 bit7: output divider open detect
// - bit6: quick output overvoltage trip
// - bits5,4: output undervolt fault, warning
// - bits3,2: output overvolt warning, fault
// - bit1: OR of overvoltage fault and quick overvoltage trip
// - bit0: any output overvoltage or undervoltage fault or warning (divider open not included)
// - reg3 bits7:3 zero, bit2 low power
// - bit1: auxiliary rail undervoltage
// - bit0: inrush relay off
`timescale 1ns/100ps
module pfc_debug_flag_bank
  import flag_bank_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire cond_t       condIn,
  input  wire logic        rdEn,
  input  wire logic [15:0] rdAddr,
  output logic      [7:0]  rdData_q,
  output logic             rdHit_q
);

  cond_t  syncA_q;
  cond_t  cond_q;
  flags_t flags_q;
  flags_t flags_d;

  // conditions arrive from other clock/analog domains
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      syncA_q <= '0;
      cond_q  <= '0;
    end
    else
    begin
      syncA_q <= condIn;
      cond_q  <= syncA_q;
    end
  end

  logic lineSummary;
  logic inputSummary;
  logic outOvSummary;
  logic outAnyFault;

  always_comb
  begin
    lineSummary  = cond_q.lineBelowTurnoff | cond_q.lineUndervoltFault;
    outOvSummary = cond_q.outputOvervoltFault | cond_q.quickOutputOvervoltTrip;
    outAnyFault  = outOvSummary | cond_q.outputOvervoltWarning
                 | cond_q.outputUndervoltFault | cond_q.outputUndervoltWarning;
    inputSummary = cond_q.lineUndervoltFault | cond_q.lineUndervoltWarning
                 | cond_q.lineOvervoltFault | cond_q.inputOverpowerWarning
                 | cond_q.inputOvercurrentWarning | cond_q.inputOvercurrentFault
                 | cond_q.quickCurrentTrip;
    flags_d.inputSupply = {lineSummary,
                           cond_q.lineBelowTurnoff,
                           cond_q.lineUndervoltFault,
                           cond_q.lineUndervoltWarning,
                           cond_q.highLine,
                           cond_q.lineSagIndicator,
                           cond_q.commMemoryLogicFault,
                           cond_q.auxRailOvervolt};
    flags_d.inputLimit  = {cond_q.lineOvervoltFault,
                           cond_q.coreRailOvervolt,
                           cond_q.inputOverpowerWarning,
                           cond_q.linePeriodUndetected,
                           cond_q.inputOvercurrentWarning,
                           cond_q.inputOvercurrentFault,
                           cond_q.quickCurrentTrip,
                           inputSummary};
    flags_d.outputVolt  = {cond_q.dividerOpenDetect,
                           cond_q.quickOutputOvervoltTrip,
                           cond_q.outputUndervoltFault,
                           cond_q.outputUndervoltWarning,
                           cond_q.outputOvervoltWarning,
                           cond_q.outputOvervoltFault,
                           outOvSummary,
                           outAnyFault};
    flags_d.powerMode   = {RSVD_VALUE,
                           cond_q.lowPowerMode,
                           cond_q.auxRailUndervolt,
                           cond_q.inrushRelayOff};
  end

  // no write path exists: flags follow live conditions only
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      flags_q <= {4{FLAGS_RESET}};
    else
      flags_q <= flags_d;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rdData_q <= FLAGS_RESET;
      rdHit_q  <= 1'b0;
    end
    else
    begin
      rdHit_q <= 1'b0;
      rdData_q <= FLAGS_RESET;
      if (rdEn)
      begin
        rdHit_q <= 1'b1;
        case (rdAddr)
          ADDR_INPUT_SUPPLY: rdData_q <= flags_q.inputSupply;
          ADDR_INPUT_LIMIT:  rdData_q <= flags_q.inputLimit;
          ADDR_OUTPUT_VOLT:  rdData_q <= flags_q.outputVolt;
          ADDR_POWER_MODE:   rdData_q <= flags_q.powerMode;
          default:           rdHit_q  <= 1'b0;
        endcase
      end
    end
  end

  // condition to register bit takes exactly three edges
  line_sag_a: assert property (@(posedge clk_sys) disable iff (reset)
    condIn.lineSagIndicator |-> ##3 flags_q.inputSupply[2])
    else $error("line sag flag not mirrored");
  period_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    !condIn.linePeriodUndetected |-> ##3 !flags_q.inputLimit[4])
    else $error("period flag stuck");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    flags_q.powerMode[7:3] == RSVD_VALUE)
    else $error("reserved bits nonzero");
  out_ov_or_a: assert property (@(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[1] == (flags_q.outputVolt[2] | flags_q.outputVolt[6]))
    else $error("overvoltage summary wrong");
  out_any_a: assert property (@(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[0] == (|flags_q.outputVolt[6:1]))
    else $error("output fault summary wrong");
  input_sum_a: assert property (@(posedge clk_sys) disable iff (reset)
    (flags_q.inputLimit[5] | flags_q.inputLimit[2]) |-> flags_q.inputLimit[0])
    else $error("input summary missing");
  uv_summary_a: assert property (@(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[5] |-> flags_q.inputSupply[7])
    else $error("undervoltage summary missing");
  read_data_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr == ADDR_OUTPUT_VOLT) |=> rdHit_q && rdData_q == $past(flags_q.outputVolt))
    else $error("read data mismatch");
  unmapped_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr[15:2] != ADDR_INPUT_SUPPLY[15:2]) |=> !rdHit_q && rdData_q == FLAGS_RESET)
    else $error("unmapped read answered");
  inrush_a: assert property (@(posedge clk_sys) disable iff (reset)
    condIn.inrushRelayOff |-> ##3 flags_q.powerMode[0])
    else $error("inrush flag not mirrored");

  // per-bit mirror: each flag equals its pin three edges earlier,
  // so both polarities and the whole synchroniser path are covered;
  // assumes pins are quiet while reset is held
  below_off_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[6] == $past(condIn.lineBelowTurnoff, 3))
    else $error("turn-off flag wrong");

  uv_fault_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[5] == $past(condIn.lineUndervoltFault, 3))
    else $error("line undervoltage fault flag wrong");

  uv_warn_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[4] == $past(condIn.lineUndervoltWarning, 3))
    else $error("line undervoltage warning flag wrong");

  high_line_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[3] == $past(condIn.highLine, 3))
    else $error("high line flag wrong");

  sag_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[2] == $past(condIn.lineSagIndicator, 3))
    else $error("line sag flag wrong");

  cml_flag_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[1] == $past(condIn.commMemoryLogicFault, 3))
    else $error("comm memory logic flag wrong");

  aux_ov_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[0] == $past(condIn.auxRailOvervolt, 3))
    else $error("aux rail overvoltage flag wrong");

  line_ov_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[7] == $past(condIn.lineOvervoltFault, 3))
    else $error("line overvoltage flag wrong");

  core_ov_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[6] == $past(condIn.coreRailOvervolt, 3))
    else $error("core rail overvoltage flag wrong");

  overpower_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[5] == $past(condIn.inputOverpowerWarning, 3))
    else $error("overpower warning flag wrong");

  period_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[4] == $past(condIn.linePeriodUndetected, 3))
    else $error("period flag wrong");

  oc_warn_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[3] == $past(condIn.inputOvercurrentWarning, 3))
    else $error("overcurrent warning flag wrong");

  oc_fault_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[2] == $past(condIn.inputOvercurrentFault, 3))
    else $error("overcurrent fault flag wrong");

  current_trip_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[1] == $past(condIn.quickCurrentTrip, 3))
    else $error("current limit trip flag wrong");

  divider_open_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[7] == $past(condIn.dividerOpenDetect, 3))
    else $error("divider open flag wrong");

  quick_ov_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[6] == $past(condIn.quickOutputOvervoltTrip, 3))
    else $error("quick overvoltage flag wrong");

  out_uv_fault_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[5] == $past(condIn.outputUndervoltFault, 3))
    else $error("output undervoltage fault flag wrong");

  out_uv_warn_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[4] == $past(condIn.outputUndervoltWarning, 3))
    else $error("output undervoltage warning flag wrong");

  out_ov_warn_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[3] == $past(condIn.outputOvervoltWarning, 3))
    else $error("output overvoltage warning flag wrong");

  out_ov_fault_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[2] == $past(condIn.outputOvervoltFault, 3))
    else $error("output overvoltage fault flag wrong");

  low_power_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.powerMode[2] == $past(condIn.lowPowerMode, 3))
    else $error("low power flag wrong");

  aux_uv_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.powerMode[1] == $past(condIn.auxRailUndervolt, 3))
    else $error("aux rail undervoltage flag wrong");

  inrush_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.powerMode[0] == $past(condIn.inrushRelayOff, 3))
    else $error("inrush flag wrong");

  // summaries checked against the pins, and two of them also against other flags
  line_sum_pin_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[7] == $past(condIn.lineBelowTurnoff | condIn.lineUndervoltFault, 3))
    else $error("line undervoltage summary wrong");

  input_sum_pin_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[0] == $past(condIn.lineUndervoltFault | condIn.lineUndervoltWarning
      | condIn.lineOvervoltFault | condIn.inputOverpowerWarning
      | condIn.inputOvercurrentWarning | condIn.inputOvercurrentFault
      | condIn.quickCurrentTrip, 3))
    else $error("input summary wrong");

  ov_sum_pin_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[1] == $past(condIn.outputOvervoltFault
      | condIn.quickOutputOvervoltTrip, 3))
    else $error("overvoltage summary from pins wrong");

  out_any_pin_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.outputVolt[0] == $past(condIn.outputOvervoltFault | condIn.quickOutputOvervoltTrip
      | condIn.outputOvervoltWarning | condIn.outputUndervoltFault
      | condIn.outputUndervoltWarning, 3))
    else $error("output fault summary from pins wrong");

  line_sum_eq_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputSupply[7] == (flags_q.inputSupply[6] | flags_q.inputSupply[5]))
    else $error("undervoltage summary extra");

  input_sum_eq_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    flags_q.inputLimit[0] == (|flags_q.inputLimit[5:1] & 1'b1) || flags_q.inputLimit[0] ==
      (flags_q.inputLimit[7] | flags_q.inputLimit[5] | (|flags_q.inputLimit[3:1])
      | flags_q.inputSupply[5] | flags_q.inputSupply[4]))
    else $error("input summary extra");

  // read port: one answer per mapped request, standing a single cycle
  read_supply_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr == ADDR_INPUT_SUPPLY) |=> rdHit_q && rdData_q == $past(flags_q.inputSupply))
    else $error("supply read data mismatch");

  read_limit_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr == ADDR_INPUT_LIMIT) |=> rdHit_q && rdData_q == $past(flags_q.inputLimit))
    else $error("limit read data mismatch");

  read_power_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr == ADDR_POWER_MODE) |=> rdHit_q && rdData_q == $past(flags_q.powerMode))
    else $error("power read data mismatch");

  read_rsvd_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (rdEn && rdAddr == ADDR_POWER_MODE) |=> rdData_q[7:3] == RSVD_VALUE)
    else $error("reserved bits read nonzero");

  read_idle_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !rdEn |=> !rdHit_q && rdData_q == FLAGS_RESET)
    else $error("answer without request");

  hit_cause_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    rdHit_q |-> $past(rdEn) && $past(rdAddr[15:2]) == ADDR_INPUT_SUPPLY[15:2])
    else $error("hit without mapped request");

  // second stage must be the input two edges later
  sync_stage_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    cond_q == $past(condIn, 2))
    else $error("synchroniser path wrong");

  read_supply_c: cover property (@(posedge clk_sys) rdEn && rdAddr == ADDR_INPUT_SUPPLY);
  read_miss_c:   cover property (@(posedge clk_sys) rdEn && rdAddr == 16'hFE9C);
  read_power_c:  cover property (@(posedge clk_sys) rdEn && rdAddr == ADDR_POWER_MODE);
  out_fault_c:   cover property (@(posedge clk_sys) flags_q.outputVolt[0]);
  input_sum_c:   cover property (@(posedge clk_sys) flags_q.inputLimit[0]);

endmodule // pfc_debug_flag_bank
